// >>> rtl/chw_pkg.sv
// Shared constants of the charger supervisory timing block
package chw_pkg;
    localparam int unsigned CLK_MHZ = 50;
    // Times in natural units; cycle counts derived from the clock rate
    localparam int unsigned INT_PULSE_US = 256;
    localparam int unsigned INT_PULSE_CYC = INT_PULSE_US * CLK_MHZ;
    localparam int unsigned WAKE_US = 500;
    localparam int unsigned WAKE_CYC = WAKE_US * CLK_MHZ;
    localparam int unsigned STBY_US = 300;
    localparam int unsigned STBY_CYC = STBY_US * CLK_MHZ;
    localparam int unsigned RXOK_US = 16;
    localparam int unsigned RXOK_CYC = RXOK_US * CLK_MHZ;
    localparam int unsigned SWITCH_DLY_MS = 2;
    localparam int unsigned SWITCH_DLY_CYC = SWITCH_DLY_MS * 1000 * CLK_MHZ;
    localparam int unsigned SS_BYP_MS = 3;
    localparam int unsigned SS_BYP_CYC = SS_BYP_MS * 1000 * CLK_MHZ;
    localparam int unsigned SS_HALV_MS = 5;
    localparam int unsigned SS_HALV_CYC = SS_HALV_MS * 1000 * CLK_MHZ;
    localparam int unsigned SS_RHALV_MS = 4;
    localparam int unsigned SS_RHALV_CYC = SS_RHALV_MS * 1000 * CLK_MHZ;
    localparam int unsigned PRECHG_MS = 2;
    localparam int unsigned PRECHG_CYC = PRECHG_MS * 1000 * CLK_MHZ;
    // Silence timeout is counted in ticks of 3.75 s (3750 ms)
    localparam int unsigned WD_TICK_MS = 3750;
    localparam int unsigned WD_TICK_CYC = WD_TICK_MS * 1000 * CLK_MHZ;
    localparam logic [2:0] WD_SEL_RST = 3'h4;
    localparam logic [1:0] SWITCH_SEL_2MS = 2'h2;
    localparam logic [6:0] ADDR_LOW = 7'h50;
    localparam logic [6:0] ADDR_FLOAT = 7'h51;
    localparam logic [6:0] ADDR_HIGH = 7'h52;
    localparam int unsigned SYNC_W = 5;
    typedef enum logic [1:0] {
        CHW_BYPASS,
        CHW_HALVING,
        CHW_REV_HALVING,
        CHW_REV_BYPASS
    } chw_mode_e;
endpackage : chw_pkg

// >>> rtl/chw_tmr_if.sv
// Start/limit/done bundle between the top and its delay timers
`timescale 1ns/100ps
`default_nettype none
interface chw_tmr_if;
    logic start;
    logic [31:0] limit;
    logic done;
    modport ctl (output start, output limit, input done);
    modport tmr (input start, input limit, output done);
endinterface : chw_tmr_if
`default_nettype wire

// >>> rtl/chw_delay.sv
// Level-qualified delay timer: done rises limit edges after start goes high
`timescale 1ns/100ps
`default_nettype none
module chw_delay (
    input wire logic sys_clk,
    input wire logic arst_n,
    chw_tmr_if.tmr t
);
    logic [31:0] cnt;
    logic done;
    wire logic [31:0] last = (t.limit == 32'h0) ? 32'h0 : t.limit - 32'h1;

    assign t.done = done;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 32'h0;
            done <= 1'b0;
        end else if (!t.start) begin
            cnt <= 32'h0;
            done <= 1'b0;
        end else if (!done) begin
            if (cnt == last) begin
                done <= 1'b1;
            end else begin
                cnt <= cnt + 32'h1;
            end
        end
    end

    delay_exact_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(done) |-> $past(cnt) == $past(last) && $past(t.start))
        else $error("Delay done at wrong count");
    delay_drop_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !t.start |=> !done)
        else $error("Delay done without start");
endmodule : chw_delay
`default_nettype wire

// >>> rtl/chw_top.sv
// Charger supervisory timing: silence timeout, interrupt pulse, strap, delays
// Overview of operation
// - A silent host link times out after 3.75 to 120 s chosen by a 3-bit code, 30 s at reset.
// - Each event that finds the open-drain interrupt released pulls it low for 256 us and then releases it.
// - The 7-bit target address is 0x50, 0x51 or 0x52 for a low, floating or high strap.
// - The host link is ready 500 us after the supply leaves lockout, and not before.
// - Moving from present mode into standby takes 300 us.
// - With delay code 10 the blocking switch starts 2 ms after the receiver input appears.
// - In standby with the bus above 5 V, receiver-ok rises 16 us after the input appears.
// - Bypass start pre-charges the output then closes the switch within 3 ms.
// - Halving start pre-charges to half input then switches within 5 ms.
// - Reverse halving starts switching within 4 ms, reverse bypass closes within 3 ms.
`timescale 1ns/100ps
`default_nettype none
module chw_top #(
    parameter int unsigned INT_CYC = chw_pkg::INT_PULSE_CYC,
    parameter int unsigned WAKE_CYC = chw_pkg::WAKE_CYC,
    parameter int unsigned STBY_CYC = chw_pkg::STBY_CYC,
    parameter int unsigned SW_DLY_CYC = chw_pkg::SWITCH_DLY_CYC,
    parameter int unsigned SW_DLY_OTHER_CYC = chw_pkg::SWITCH_DLY_CYC,
    parameter int unsigned PRE_CYC = chw_pkg::PRECHG_CYC,
    parameter int unsigned SS_BYP_CYC = chw_pkg::SS_BYP_CYC,
    parameter int unsigned SS_HALV_CYC = chw_pkg::SS_HALV_CYC,
    parameter int unsigned SS_RHALV_CYC = chw_pkg::SS_RHALV_CYC,
    parameter int unsigned WD_TICK_CYC = chw_pkg::WD_TICK_CYC
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic i2c_hit,
    input wire logic wd_sel_wr,
    input wire logic [2:0] wd_sel,
    input wire logic event_req,
    input wire logic supply_ok,
    input wire logic rx_present,
    input wire logic bus_above_5v,
    input wire logic strap_above_low,
    input wire logic strap_above_mid,
    input wire logic standby_req,
    input wire logic [1:0] switch_dly_sel,
    input wire logic mode_en,
    input wire chw_pkg::chw_mode_e mode_sel,
    output logic host_silence_timeout,
    output logic int_o,
    output logic int_oe,
    output logic [6:0] target_addr,
    output logic i2c_ready,
    output logic standby_done,
    output logic input_blocking_switch,
    output logic rx_ok,
    output logic precharge_on,
    output logic switch_on
);
    import chw_pkg::*;

    function automatic logic [5:0] wd_ticks(input logic [2:0] code);
        unique case (code)
            3'h0: wd_ticks = 6'h01;
            3'h1: wd_ticks = 6'h02;
            3'h2: wd_ticks = 6'h03;
            3'h3: wd_ticks = 6'h04;
            3'h4: wd_ticks = 6'h08;
            3'h5: wd_ticks = 6'h10;
            3'h6: wd_ticks = 6'h18;
            3'h7: wd_ticks = 6'h20;
        endcase
    endfunction : wd_ticks

    // Pin synchronisers: three stages, a change counts once stages 2 and 3 agree
    logic [SYNC_W-1:0] s1, s2, s3, pin;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            pin <= '0;
        end else begin
            s1 <= {supply_ok, rx_present, bus_above_5v, strap_above_low, strap_above_mid};
            s2 <= s1;
            s3 <= s2;
            pin <= (s2 & s3) | (pin & (s2 ^ s3));
        end
    end
    wire logic supply_f = pin[4];
    wire logic rx_f = pin[3];
    wire logic bus5_f = pin[2];
    wire logic strap_lo_f = pin[1];
    wire logic strap_hi_f = pin[0];

    // Silence timeout
    logic [2:0] wd_code;
    logic [31:0] wd_pcnt;
    logic [5:0] wd_tcnt;
    wire logic wd_tick = (wd_pcnt == 32'(WD_TICK_CYC - 1));
    wire logic wd_fire = wd_tick && (wd_tcnt == wd_ticks(wd_code) - 6'h1) && !i2c_hit;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wd_code <= WD_SEL_RST;
            wd_pcnt <= 32'h0;
            wd_tcnt <= 6'h0;
            host_silence_timeout <= 1'b0;
        end else begin
            if (wd_sel_wr) wd_code <= wd_sel;
            host_silence_timeout <= wd_fire;
            if (i2c_hit || wd_fire || wd_sel_wr) begin
                wd_pcnt <= 32'h0;
                wd_tcnt <= 6'h0;
            end else if (wd_tick) begin
                wd_pcnt <= 32'h0;
                wd_tcnt <= wd_tcnt + 6'h1;
            end else begin
                wd_pcnt <= wd_pcnt + 32'h1;
            end
        end
    end

    // Interrupt pulse; events during a pulse merge into it
    wire logic int_trig = event_req || wd_fire;
    logic [31:0] int_cnt;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            int_o <= 1'b0;
            int_oe <= 1'b0;
            int_cnt <= 32'h0;
        end else if (int_trig && !int_oe) begin
            int_oe <= 1'b1;
            int_cnt <= 32'(INT_CYC - 1);
        end else if (int_oe) begin
            if (int_cnt == 32'h0) int_oe <= 1'b0;
            else int_cnt <= int_cnt - 32'h1;
        end
    end

    // Strap decode, followed continuously after the filter settles
    wire logic [6:0] next_addr = strap_hi_f ? ADDR_HIGH : (strap_lo_f ? ADDR_FLOAT : ADDR_LOW);

    // Delay timers
    chw_tmr_if wake_t ();
    chw_tmr_if stby_t ();
    chw_tmr_if sw_t ();
    chw_tmr_if rxok_t ();
    chw_tmr_if ss_t ();
    assign wake_t.start = supply_f;
    assign wake_t.limit = 32'(WAKE_CYC);
    assign stby_t.start = standby_req;
    assign stby_t.limit = 32'(STBY_CYC);
    assign sw_t.start = rx_f;
    assign sw_t.limit = (switch_dly_sel == SWITCH_SEL_2MS) ? 32'(SW_DLY_CYC) : 32'(SW_DLY_OTHER_CYC);
    assign rxok_t.start = rx_f && bus5_f && stby_t.done;
    assign rxok_t.limit = 32'(RXOK_CYC);
    chw_delay u_wake (.sys_clk(sys_clk), .arst_n(arst_n), .t(wake_t));
    chw_delay u_stby (.sys_clk(sys_clk), .arst_n(arst_n), .t(stby_t));
    chw_delay u_sw (.sys_clk(sys_clk), .arst_n(arst_n), .t(sw_t));
    chw_delay u_rxok (.sys_clk(sys_clk), .arst_n(arst_n), .t(rxok_t));

    // Soft start: pre-charge, then run; reverse bypass pre-charges with a timer limit of 1 cycle only
    typedef enum logic [1:0] {SS_IDLE, SS_PRE, SS_RUN} chw_ss_e;
    chw_ss_e ss_st;
    assign ss_t.start = (ss_st == SS_PRE);
    assign ss_t.limit = (mode_sel == CHW_REV_BYPASS) ? 32'h1 : 32'(PRE_CYC);
    chw_delay u_ss (.sys_clk(sys_clk), .arst_n(arst_n), .t(ss_t));
    wire logic [31:0] ss_lim = (mode_sel == CHW_HALVING) ? 32'(SS_HALV_CYC) :
        (mode_sel == CHW_REV_HALVING) ? 32'(SS_RHALV_CYC) : 32'(SS_BYP_CYC);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ss_st <= SS_IDLE;
        end else if (!mode_en) begin
            ss_st <= SS_IDLE;
        end else begin
            unique case (ss_st)
                SS_IDLE: ss_st <= SS_PRE;
                SS_PRE: if (ss_t.done) ss_st <= SS_RUN;
                SS_RUN: ss_st <= SS_RUN;
            endcase
        end
    end

    // Registered outputs; each adds one cycle after its timer, the soft-start state or the strap decode
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            target_addr <= ADDR_LOW;
            i2c_ready <= 1'b0;
            standby_done <= 1'b0;
            input_blocking_switch <= 1'b0;
            rx_ok <= 1'b0;
            precharge_on <= 1'b0;
            switch_on <= 1'b0;
        end else begin
            target_addr <= next_addr;
            i2c_ready <= wake_t.done;
            standby_done <= stby_t.done;
            input_blocking_switch <= sw_t.done;
            rx_ok <= rxok_t.done;
            precharge_on <= (ss_st == SS_PRE) && mode_en;
            switch_on <= (ss_st == SS_RUN) && mode_en;
        end
    end

    // Helper counters read only by assertions
    logic [63:0] sil;
    logic [31:0] int_len, ss_len;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sil <= 64'h0;
            int_len <= 32'h0;
            ss_len <= 32'h0;
        end else begin
            sil <= (i2c_hit || wd_fire || wd_sel_wr) ? 64'h0 : sil + 64'h1;
            int_len <= int_oe ? int_len + 32'h1 : 32'h0;
            ss_len <= (ss_st == SS_PRE) ? ss_len + 32'h1 : 32'h0;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence hit_seen;
        i2c_hit;
    endsequence
    sequence timeout_quiet;
        !host_silence_timeout;
    endsequence

    wd_period_a: assert property (wd_fire |->
        sil == 64'(wd_ticks(wd_code)) * 64'(WD_TICK_CYC) - 64'h1)
        else $error("Silence timeout at wrong time");
    wd_restart_a: assert property (hit_seen |=> timeout_quiet ##0 sil == 64'h0)
        else $error("Host traffic did not restart count");
    int_width_a: assert property ($fell(int_oe) |-> int_len == 32'(INT_CYC))
        else $error("Interrupt pulse has wrong width");
    int_low_a: assert property (int_oe |-> !int_o)
        else $error("Interrupt driven high");
    strap_map_a: assert property ((s3 == s2) ##1 (s3 == s2) ##2 1'b1 |->
        target_addr == (strap_hi_f ? ADDR_HIGH : (strap_lo_f ? ADDR_FLOAT : ADDR_LOW)) ||
        $changed(pin))
        else $error("Target address does not match strap");
    ready_supply_a: assert property (i2c_ready |-> $past(supply_f, 2))
        else $error("Ready without supply");
    rxok_cause_a: assert property ($rose(rx_ok) |-> $past(rx_f, 2) && $past(bus5_f, 2))
        else $error("Receiver-ok without cause");
    ss_bound_a: assert property ((ss_st == SS_PRE) |-> ss_len < ss_lim)
        else $error("Soft start over its limit");
    switch_order_a: assert property ($rose(switch_on) |-> $past(precharge_on))
        else $error("Switching without pre-charge");
endmodule : chw_top
`default_nettype wire

// >>> verif/chw_host_model.sv
// Host model: issues transactions addressed to the device once it is up
`timescale 1ns/100ps
`default_nettype none
module chw_host_model (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic i2c_ready,
    input wire logic xfer_req,
    output logic i2c_hit
);
    logic pend;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pend <= 1'b0;
            i2c_hit <= 1'b0;
        end else begin
            // Requests before wake-up are held, not lost
            i2c_hit <= (pend | xfer_req) & i2c_ready;
            pend <= (pend | xfer_req) & ~i2c_ready;
        end
    end
endmodule : chw_host_model
`default_nettype wire

// >>> verif/charger_host_watchdog_timing_tb_top.sv
// Self-checking bench of the charger supervisory timing block
`timescale 1ns/100ps
`default_nettype none
module charger_host_watchdog_timing_tb_top;
    import chw_pkg::*;
    localparam int T_INT = 20;
    localparam int T_WAKE = 30;
    localparam int T_STBY = 20;
    localparam int T_SW = 40;
    localparam int T_SWO = 10;
    localparam int T_PRE = 25;
    localparam int T_BYP = 50;
    localparam int T_HALV = 60;
    localparam int T_RHALV = 55;
    localparam int T_TICK = 10;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic xfer_req = 1'b0;
    logic i2c_hit;
    logic wd_sel_wr = 1'b0;
    logic [2:0] wd_sel = 3'h0;
    logic event_req = 1'b0;
    logic supply_ok = 1'b0;
    logic rx_present = 1'b0;
    logic bus_above_5v = 1'b0;
    logic strap_lo = 1'b0;
    logic strap_mid = 1'b0;
    logic standby_req = 1'b0;
    logic [1:0] sw_sel = 2'h0;
    logic mode_en = 1'b0;
    chw_mode_e mode_sel = CHW_BYPASS;
    logic tmo, int_o, int_oe, rdy, sb_done, ibs, rx_ok, pre_on, sw_on;
    logic [6:0] target_addr;
    int n_fail = 0;
    int n_checks = 0;
    int n;
    int m;
    int lim;
    always #10 sys_clk = ~sys_clk;
    chw_top #(.INT_CYC(T_INT), .WAKE_CYC(T_WAKE), .STBY_CYC(T_STBY), .SW_DLY_CYC(T_SW),
        .SW_DLY_OTHER_CYC(T_SWO), .PRE_CYC(T_PRE), .SS_BYP_CYC(T_BYP),
        .SS_HALV_CYC(T_HALV), .SS_RHALV_CYC(T_RHALV), .WD_TICK_CYC(T_TICK)) DUT (
        .sys_clk(sys_clk), .arst_n(arst_n), .i2c_hit(i2c_hit), .wd_sel_wr(wd_sel_wr),
        .wd_sel(wd_sel), .event_req(event_req), .supply_ok(supply_ok),
        .rx_present(rx_present), .bus_above_5v(bus_above_5v), .strap_above_low(strap_lo),
        .strap_above_mid(strap_mid), .standby_req(standby_req), .switch_dly_sel(sw_sel),
        .mode_en(mode_en), .mode_sel(mode_sel), .host_silence_timeout(tmo), .int_o(int_o),
        .int_oe(int_oe), .target_addr(target_addr), .i2c_ready(rdy),
        .standby_done(sb_done), .input_blocking_switch(ibs), .rx_ok(rx_ok),
        .precharge_on(pre_on), .switch_on(sw_on));
    chw_host_model host (.sys_clk(sys_clk), .arst_n(arst_n), .i2c_ready(rdy),
        .xfer_req(xfer_req), .i2c_hit(i2c_hit));
    task automatic complete_run();
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #2;
    endtask : tick
    function automatic int wd_cyc(input int c);
        int t[8] = '{1, 2, 3, 4, 8, 16, 24, 32};
        return T_TICK * t[c];
    endfunction : wd_cyc
    function automatic int ss_lim(input int k);
        return k == 1 ? T_HALV : k == 2 ? T_RHALV : T_BYP;
    endfunction : ss_lim
    function automatic logic pick(input int k);
        case (k)
            0: return tmo;
            1: return int_oe;
            2: return ~int_oe;
            3: return rdy;
            4: return sb_done;
            5: return ibs;
            6: return rx_ok;
            7: return sw_on;
            default: return ~(pre_on | sw_on);
        endcase
    endfunction : pick
    // Edges until the picked output is high; a bound keeps a hang out
    task automatic measure(input int k, input int lim, output int cnt);
        cnt = 0;
        while (pick(k) !== 1'b1) begin
            tick(1);
            cnt++;
            if (cnt > lim) begin
                n_fail++;
                $display("Error %0t: wait %0d ran out", $time, k);
                complete_run();
            end
        end
    endtask : measure
    task automatic check_rng(input int got, input int lo, input int hi);
        n_checks++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("Error %0t: count %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask : check_rng
    task automatic check_val(input logic [6:0] got, input logic [6:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t: value %h expected %h", $time, got, exp);
        end
    endtask : check_val
    initial begin
        void'($urandom(32'hb7fb5870));
        tick(6);
        check_val(target_addr, ADDR_LOW);
        check_val({int_oe, rdy, sb_done, ibs, rx_ok, sw_on, tmo}, 7'h0);
        arst_n = 1'b1;
        measure(0, 200, n);
        check_rng(n, wd_cyc(4) - 1, wd_cyc(4) + 2);
        supply_ok = 1'b1;
        bus_above_5v = 1'b1;
        measure(3, 200, n);
        check_rng(n, T_WAKE + 3, T_WAKE + 6);
        for (int i = 0; i < 3; i++) begin
            strap_lo = (i > 0);
            strap_mid = (i > 1);
            tick(8);
            check_val(target_addr, i == 0 ? ADDR_LOW : i == 1 ? ADDR_FLOAT : ADDR_HIGH);
        end
        for (int c = 0; c < 8; c++) begin
            m = wd_cyc(c);
            wd_sel = c[2:0];
            wd_sel_wr = 1'b1;
            tick(1);
            wd_sel_wr = 1'b0;
            measure(0, m + 9, n);
            check_rng(n + 1, m, m + 2);
            tick(1);
            check_val(7'(int_oe), 7'h1);
            tick($urandom_range(m - 4, 1));
            xfer_req = 1'b1;
            tick(1);
            xfer_req = 1'b0;
            measure(0, m + 9, n);
            check_rng(n + 1, m + 1, m + 3);
        end
        tick(25);
        event_req = 1'b1;
        tick(1);
        event_req = 1'b0;
        measure(1, 5, n);
        check_rng(n + 1, 1, 1);
        tick(5);
        check_val(7'(int_o), 7'h0);
        event_req = 1'b1;
        tick(1);
        event_req = 1'b0;
        measure(2, 40, n);
        check_rng(n + 6, T_INT, T_INT);
        standby_req = 1'b1;
        measure(4, 60, n);
        check_rng(n, T_STBY + 1, T_STBY + 3);
        for (int j = 0; j < 2; j++) begin
            sw_sel = j == 0 ? SWITCH_SEL_2MS : 2'($urandom_range(1, 0));
            lim = j == 0 ? T_SW : T_SWO;
            rx_present = 1'b1;
            measure(5, lim + 20, n);
            check_rng(n, lim + 3, lim + 6);
            if (j == 0) begin
                measure(6, 900, m);
                check_rng(n + m, RXOK_CYC + 3, RXOK_CYC + 6);
            end
            rx_present = 1'b0;
            tick(10);
        end
        standby_req = 1'b0;
        for (int k = 0; k < 4; k++) begin
            mode_sel = chw_mode_e'(k);
            mode_en = 1'b1;
            tick(2);
            check_val(7'(pre_on), 7'h1);
            measure(7, 200, n);
            check_rng(n, k < 3 ? T_PRE : 1, ss_lim(k));
            mode_en = 1'b0;
            measure(8, 5, n);
            check_rng(n, 1, 2);
            tick(2);
        end
        complete_run();
    end
endmodule : charger_host_watchdog_timing_tb_top
`default_nettype wire
